// ### common/rps_cfg.svh
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// How it works
// - Every rail holds a slot number, a power-up delay and a power-down delay, 1 s by default.
// - Power-up enables the rails one slot at a time in ascending slot order.
// - The next slot starts only once the rail just enabled has reached its first low limit.
// - With reverse order set, power-down walks the slots backwards with each down delay.
// - A power-down request starts the down sequence, one rail per down delay.
// - A kill input drops its rail enable at once, outside the sequence.
// - An output that follows the nominal condition is active once a power-up has started and the rail is at nominal.
// - Each output has its own polarity; active low drives the pin low while true.
// - Each rail is compared with two high limits that, once a power-up has started, activate their outputs when reached.
// - Each rail is compared with two low limits that, once a power-up has started, activate their outputs when reached.
// - Limit outputs stay inactive while the rail sits between the low and high limits.
// - Rising edges of the up and down request inputs start the two sequences.

// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define RPS_NRAIL      4
`define RPS_NOUT       8
`define RPS_CLK_HZ     200000000
`define RPS_TICK_US    1000
`define RPS_TICK_CYC   (`RPS_TICK_US * (`RPS_CLK_HZ / 1000000))
`define RPS_DLY_S      1
`define RPS_DLY_TICKS  (`RPS_DLY_S * 1000000 / `RPS_TICK_US)

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RPS_CTRL_OFF   12'h000
`define RPS_STAT_OFF   12'h004
`define RPS_ISTAT_OFF  12'h008
`define RPS_IMASK_OFF  12'h00C
`define RPS_COND_OFF   12'h010
`define RPS_RAIL_BASE  4'h1
`define RPS_OUT_BASE   4'h2
`define RPS_F_LOW      2'h0
`define RPS_F_HIGH     2'h1
`define RPS_F_NOM      2'h2
`define RPS_F_DLY      2'h3

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RPS_CTRL_LOADED  0
`define RPS_CTRL_REVERSE 1
`define RPS_CTRL_RST     2'h2
`define RPS_EV_UP        0
`define RPS_EV_DN        1
`define RPS_EV_KILL      2
`define RPS_OS_POL       8
`define RPS_OSEL_RST     9'h000
`define RPS_HIGH1_RST    16'h0BB8
`define RPS_HIGH2_RST    16'h0C80
`define RPS_LOW1_RST     16'h0A28
`define RPS_LOW2_RST     16'h0960
`define RPS_NOM_RST      16'h0AF0
`define RPS_DLY_RST      16'(`RPS_DLY_TICKS)

`endif

// ### common/rps_pkg.sv
package rps_pkg;
    typedef logic [15:0]       rps_mv_t;
    typedef logic [3:0][15:0]  rps_mv_bus_t;
    typedef enum logic [2:0] {ST_IDLE, ST_UP_DLY, ST_UP_CHK, ST_ON, ST_DN_DLY} rps_state_t;
    typedef enum logic [2:0] {CND_NONE, CND_NOM, CND_LOW1, CND_LOW2, CND_HIGH1,
                              CND_HIGH2} rps_cond_t;
endpackage

// ### hw/rps_tick.sv
`timescale 1ns/10ps

module rps_tick #(
    parameter int unsigned TICK_CYC = 200000
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      tick
);
    logic [31:0] cnt_q;
    logic [31:0] gap_q;
    logic        seen_q;

    assign tick = (cnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= 32'h0;
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            cnt_q  <= tick ? 32'h0 : cnt_q + 32'h1;
            gap_q  <= tick ? 32'h0 : gap_q + 32'h1;
            seen_q <= seen_q | tick;
        end
    end

    property p_tick_gap;
        @(posedge hclk) disable iff (!hresetn)
        (tick && seen_q) |-> gap_q == 32'(TICK_CYC - 1);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("Tick spacing wrong.");
endmodule

// ### hw/rps_cmp.sv
`timescale 1ns/10ps

module rps_cmp (
    input  wire rps_pkg::rps_mv_t mv,
    input  wire rps_pkg::rps_mv_t low_first,
    input  wire rps_pkg::rps_mv_t low_second,
    input  wire rps_pkg::rps_mv_t high_first,
    input  wire rps_pkg::rps_mv_t high_second,
    input  wire rps_pkg::rps_mv_t nominal,
    output logic [4:0]            flags
);
    import rps_pkg::*;

    assign flags[0] = (mv >= nominal) && (mv < high_first);
    assign flags[1] = (mv <= low_first);
    assign flags[2] = (mv <= low_second);
    assign flags[3] = (mv >= high_first);
    assign flags[4] = (mv >= high_second);
endmodule

// ### hw/rps_top.sv
`timescale 1ns/10ps
`include "rps_cfg.svh"

module rps_top #(
    parameter int unsigned TICK_CYC = `RPS_TICK_CYC
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    input  wire logic                 pwr_up_req,
    input  wire logic                 pwr_dn_req,
    input  wire rps_pkg::rps_mv_bus_t rail_mv,
    input  wire logic [3:0]           rail_kill,
    output logic [3:0]                rail_en,
    output logic [7:0]                dout,
    output logic                      irq
);
    import rps_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic        wr_pend_q;
    logic [11:0] waddr_q;
    logic        hreadyout_q;
    logic [31:0] hrdata_q;
    logic        hresp_q;
    logic [1:0]  ctrl_q;
    logic [2:0]  istat_q;
    logic [2:0]  istat_d;
    logic [2:0]  imask_q;
    logic        irq_q;
    logic [31:0] low_q  [4];
    logic [31:0] high_q [4];
    logic [31:0] nom_q  [4];
    logic [31:0] dly_q  [4];
    logic [8:0]  osel_q [8];
    logic [4:0]  flags  [4];
    logic [3:0]  risen;
    logic [7:0]  hit;
    logic [7:0]  dout_q;
    rps_state_t  state_q;
    rps_state_t  state_d;
    logic [1:0]  slot_q;
    logic [1:0]  slot_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [3:0]  rail_en_q;
    logic [3:0]  en_d;
    logic        run_q;
    logic        up_req_q;
    logic        dn_req_q;
    logic [1:0]  cur;
    logic        ev_up;
    logic        ev_dn;
    logic        tick;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire        take      = hsel & hready & htrans[1];
    wire        in_map    = (haddr[31:12] == 20'h0);
    wire [11:0] raddr     = haddr[11:0];
    wire [1:0]  r_rail    = raddr[5:4];
    wire [1:0]  r_fld     = raddr[3:2];
    wire [2:0]  r_out     = raddr[4:2];
    wire        r_is_rail = (raddr[11:8] == `RPS_RAIL_BASE) && (raddr[7:6] == 2'h0);
    wire        r_is_out  = (raddr[11:8] == `RPS_OUT_BASE) && (raddr[7:5] == 3'h0);
    wire [31:0] rail_rd   = (r_fld == `RPS_F_LOW)  ? low_q[r_rail]  :
                            (r_fld == `RPS_F_HIGH) ? high_q[r_rail] :
                            (r_fld == `RPS_F_NOM)  ? nom_q[r_rail]  : dly_q[r_rail];
    wire [31:0] stat_rd   = {20'h0, slot_q, 3'h0, state_q, rail_en_q};
    wire [31:0] rd_data   = !in_map                     ? 32'h0 :
                            r_is_rail                   ? rail_rd :
                            r_is_out                    ? {23'h0, osel_q[r_out]} :
                            (raddr == `RPS_CTRL_OFF)  ? {30'h0, ctrl_q} :
                            (raddr == `RPS_STAT_OFF)  ? stat_rd :
                            (raddr == `RPS_ISTAT_OFF) ? {29'h0, istat_q} :
                            (raddr == `RPS_IMASK_OFF) ? {29'h0, imask_q} :
                            (raddr == `RPS_COND_OFF)  ? {24'h0, hit} : 32'h0;

    wire        w_ctrl  = wr_pend_q & (waddr_q == `RPS_CTRL_OFF);
    wire        w_istat = wr_pend_q & (waddr_q == `RPS_ISTAT_OFF);
    wire        w_imask = wr_pend_q & (waddr_q == `RPS_IMASK_OFF);
    wire        w_rail  = wr_pend_q & (waddr_q[11:8] == `RPS_RAIL_BASE) &
                          (waddr_q[7:6] == 2'h0);
    wire        w_out   = wr_pend_q & (waddr_q[11:8] == `RPS_OUT_BASE) &
                          (waddr_q[7:5] == 3'h0);
    wire [1:0]  w_idx   = waddr_q[5:4];
    wire [1:0]  w_fld   = waddr_q[3:2];
    wire [2:0]  w_oidx  = waddr_q[4:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q   <= 1'b0;
            waddr_q     <= 12'h000;
            hreadyout_q <= 1'b0;
            hrdata_q    <= 32'h0;
            hresp_q     <= 1'b0;
        end else begin
            wr_pend_q   <= take & hwrite & in_map;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            if (take) begin
                waddr_q <= raddr;
            end
            if (take & ~hwrite) begin
                hrdata_q <= rd_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control and interrupt registers
    // ----------------------------------------------------------------
    wire [2:0] ev = {|(rail_kill & rail_en_q), ev_dn, ev_up};

    // Set wins over a write-one clear in the same cycle.
    assign istat_d = (istat_q & ~(w_istat ? hwdata[2:0] : 3'h0)) | ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= `RPS_CTRL_RST;
            istat_q <= 3'h0;
            imask_q <= 3'h0;
            irq_q   <= 1'b0;
        end else begin
            ctrl_q  <= w_ctrl ? hwdata[1:0] : ctrl_q;
            imask_q <= w_imask ? hwdata[2:0] : imask_q;
            istat_q <= istat_d;
            irq_q   <= |(istat_q & imask_q);
        end
    end

    // ----------------------------------------------------------------
    // Per rail configuration and comparison
    // ----------------------------------------------------------------
    for (genvar r = 0; r < `RPS_NRAIL; r++) begin : g_rail
        wire we = w_rail & (w_idx == 2'(r));

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                low_q[r]  <= {`RPS_LOW2_RST, `RPS_LOW1_RST};
                high_q[r] <= {`RPS_HIGH2_RST, `RPS_HIGH1_RST};
                nom_q[r]  <= {14'h0, 2'(r), `RPS_NOM_RST};
                dly_q[r]  <= {`RPS_DLY_RST, `RPS_DLY_RST};
            end else if (we) begin
                case (w_fld)
                    `RPS_F_LOW: begin
                        low_q[r] <= hwdata;
                    end
                    `RPS_F_HIGH: begin
                        high_q[r] <= hwdata;
                    end
                    `RPS_F_NOM: begin
                        nom_q[r] <= {14'h0, hwdata[17:0]};
                    end
                    default: begin
                        dly_q[r] <= hwdata;
                    end
                endcase
            end
        end

        rps_cmp u_cmp (
            .mv          (rail_mv[r]),
            .low_first   (low_q[r][15:0]),
            .low_second  (low_q[r][31:16]),
            .high_first  (high_q[r][15:0]),
            .high_second (high_q[r][31:16]),
            .nominal     (nom_q[r][15:0]),
            .flags       (flags[r])
        );

        assign risen[r] = (rail_mv[r] >= low_q[r][15:0]);
    end

    // ----------------------------------------------------------------
    // Digital outputs
    // ----------------------------------------------------------------
    for (genvar o = 0; o < `RPS_NOUT; o++) begin : g_out
        wire [7:0] fx   = {2'h0, flags[osel_q[o][1:0]], 1'b0};
        rps_cond_t code;

        assign code = rps_cond_t'(osel_q[o][4:2]);
        assign hit[o] = run_q & fx[code];

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                osel_q[o] <= `RPS_OSEL_RST;
                dout_q[o] <= 1'b0;
            end else begin
                osel_q[o] <= (w_out & (w_oidx == 3'(o))) ? hwdata[8:0] : osel_q[o];
                dout_q[o] <= hit[o] ^ osel_q[o][`RPS_OS_POL];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    rps_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    wire        up_rise  = pwr_up_req & ~up_req_q;
    wire        dn_rise  = pwr_dn_req & ~dn_req_q;
    wire        loaded   = ctrl_q[`RPS_CTRL_LOADED];
    wire        reverse  = ctrl_q[`RPS_CTRL_REVERSE];
    wire        up_done  = (cnt_q >= dly_q[cur][15:0]);
    wire        dn_done  = (cnt_q >= dly_q[cur][31:16]);
    wire        last_up  = (slot_q == 2'h3);
    wire        last_dn  = reverse ? (slot_q == 2'h0) : (slot_q == 2'h3);
    wire [1:0]  dn_first = reverse ? 2'h3 : 2'h0;
    wire [1:0]  dn_next  = reverse ? slot_q - 2'h1 : slot_q + 2'h1;
    wire        dn_go    = dn_rise && (state_q != ST_IDLE) && (state_q != ST_DN_DLY);

    always_comb begin
        cur = 2'h0;
        for (int r = 0; r < `RPS_NRAIL; r++) begin
            if (nom_q[r][17:16] == slot_q) begin
                cur = 2'(r);
            end
        end
    end

    always_comb begin
        state_d = state_q;
        slot_d  = slot_q;
        cnt_d   = cnt_q;
        en_d    = rail_en_q;
        ev_up   = 1'b0;
        ev_dn   = 1'b0;
        if (tick && (cnt_q != 16'hFFFF)) begin
            cnt_d = cnt_q + 16'h0001;
        end
        case (state_q)
            ST_IDLE: begin
                if (up_rise && loaded) begin
                    state_d = ST_UP_DLY;
                    slot_d  = 2'h0;
                    cnt_d   = 16'h0000;
                end
            end
            ST_UP_DLY: begin
                if (up_done) begin
                    en_d[cur] = 1'b1;
                    state_d   = ST_UP_CHK;
                end
            end
            ST_UP_CHK: begin
                if (risen[cur]) begin
                    if (last_up) begin
                        state_d = ST_ON;
                        ev_up   = 1'b1;
                    end else begin
                        state_d = ST_UP_DLY;
                        slot_d  = slot_q + 2'h1;
                        cnt_d   = 16'h0000;
                    end
                end
            end
            ST_DN_DLY: begin
                if (dn_done) begin
                    en_d[cur] = 1'b0;
                    cnt_d     = 16'h0000;
                    if (last_dn) begin
                        state_d = ST_IDLE;
                        ev_dn   = 1'b1;
                    end else begin
                        slot_d = dn_next;
                    end
                end
            end
            default: begin
                state_d = state_q;
            end
        endcase
        if (dn_go) begin
            state_d = ST_DN_DLY;
            slot_d  = dn_first;
            cnt_d   = 16'h0000;
            en_d    = rail_en_q;
        end
        en_d = en_d & ~rail_kill;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= ST_IDLE;
            slot_q    <= 2'h0;
            cnt_q     <= 16'h0000;
            rail_en_q <= 4'h0;
            run_q     <= 1'b0;
            up_req_q  <= 1'b0;
            dn_req_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            slot_q    <= slot_d;
            cnt_q     <= cnt_d;
            rail_en_q <= en_d;
            run_q     <= run_q | (state_q == ST_IDLE && up_rise && loaded);
            up_req_q  <= pwr_up_req;
            dn_req_q  <= pwr_dn_req;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata    = hrdata_q;
    assign hresp     = hresp_q;
    assign rail_en   = rail_en_q;
    assign dout      = dout_q;
    assign irq       = irq_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_start;
        state_q == ST_IDLE && up_rise && loaded;
    endsequence
    sequence s_down_end;
        state_q == ST_DN_DLY && dn_done && last_dn && !dn_go;
    endsequence

    property p_start;
        @(posedge hclk) disable iff (!hresetn)
        s_start |=> state_q == ST_UP_DLY && slot_q == 2'h0 && run_q;
    endproperty
    a_start: assert property (p_start) else $error("Power-up did not start.");

    property p_one_up;
        @(posedge hclk) disable iff (!hresetn)
        $countones(rail_en_q & ~$past(rail_en_q)) <= 1;
    endproperty
    a_one_up: assert property (p_one_up) else $error("Two rails rose together.");

    property p_gate;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == ST_UP_CHK && !risen[cur]) |=> state_q != ST_UP_DLY && state_q != ST_ON;
    endproperty
    a_gate: assert property (p_gate) else $error("Slot advanced early.");

    property p_kill;
        @(posedge hclk) disable iff (!hresetn)
        ((rail_kill & rail_en_q) != 4'h0) |=> (rail_en_q & $past(rail_kill)) == 4'h0;
    endproperty
    a_kill: assert property (p_kill) else $error("Killed rail stayed on.");

    property p_quiet;
        @(posedge hclk) disable iff (!hresetn)
        !run_q |-> rail_en_q == 4'h0 && hit == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("Activity before start.");

    property p_pol;
        @(posedge hclk) disable iff (!hresetn)
        (hit[0] && osel_q[0][`RPS_OS_POL]) |=> !dout_q[0];
    endproperty
    a_pol: assert property (p_pol) else $error("Active low output not low.");

    property p_rev;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == ST_DN_DLY && dn_done && !last_dn && reverse) |=>
            slot_q == $past(slot_q) - 2'h1 && state_q == ST_DN_DLY;
    endproperty
    a_rev: assert property (p_rev) else $error("Reverse step wrong.");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == ST_UP_DLY && !up_done) |=> (rail_en_q & ~$past(rail_en_q)) == 4'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("Rail enabled before delay.");

    property p_down_end;
        @(posedge hclk) disable iff (!hresetn)
        s_down_end |=> state_q == ST_IDLE && istat_q[`RPS_EV_DN];
    endproperty
    a_down_end: assert property (p_down_end) else $error("Down sequence end lost.");
endmodule

// ### sim/rps_reg_model.sv
`timescale 1ns/10ps

module rps_reg_model (
    input  wire logic                 hclk,
    input  wire logic [3:0]           rail_en,
    input  wire logic                 trim_on,
    input  wire rps_pkg::rps_mv_t     trim_mv,
    output rps_pkg::rps_mv_bus_t      rail_mv
);
    import rps_pkg::*;
    initial rail_mv = '0;
    always @(posedge hclk) begin
        for (int r = 0; r < 4; r++) begin
            rail_mv[r] <= rail_en[r] ? 16'h0AF0 : 16'h0000;
        end
        if (trim_on) begin
            rail_mv[0] <= trim_mv;
        end
    end
endmodule

// ### sim/rps_tb_top.sv
`timescale 1ns/10ps

module rps_tb_top;
    import rps_pkg::*;
    localparam int unsigned TICK = 4;
    localparam rps_mv_t LV [9] = '{16'h0960, 16'h0961, 16'h0A28, 16'h0A29, 16'h0AF0,
                                   16'h0BB7, 16'h0BB8, 16'h0C7F, 16'h0C80};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        pwr_up_req = 1'b0;
    logic        pwr_dn_req = 1'b0;
    logic [3:0]  rail_kill = '0;
    logic [3:0]  rail_en;
    logic [7:0]  dout;
    logic        irq;
    logic        trim_on = 1'b0;
    rps_mv_t     trim_mv = '0;
    rps_mv_bus_t rail_mv;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [31:0] rd;

    always #2.5 hclk = ~hclk;

    rps_top #(
        .TICK_CYC (TICK)
    ) u_rps_top (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (3'h2),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hreadyout  (hreadyout),
        .hrdata     (hrdata),
        .hresp      (hresp),
        .pwr_up_req (pwr_up_req),
        .pwr_dn_req (pwr_dn_req),
        .rail_mv    (rail_mv),
        .rail_kill  (rail_kill),
        .rail_en    (rail_en),
        .dout       (dout),
        .irq        (irq)
    );
    rps_reg_model u_rps_reg_model (
        .hclk    (hclk),
        .rail_en (rail_en),
        .trim_on (trim_on),
        .trim_mv (trim_mv),
        .rail_mv (rail_mv)
    );

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_rdy();
        for (int k = 0; k < 50; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        n_mismatch++;
        end_of_test();
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wait_en(input logic [3:0] exp, output int n);
        for (n = 0; n < 400; n++) begin
            @(posedge hclk);
            if (rail_en === exp) return;
        end
        chk("rail_en", 32'(exp), 32'(rail_en));
        end_of_test();
    endtask

    task automatic scn_reset();
        chk("rail_en", 32'h0, 32'(rail_en));
        ahb(1'b0, 32'h000, '0);
        chk("ctrl", 32'h2, rd);
        ahb(1'b0, 32'h100, '0);
        chk("rail0 low", 32'h0960_0A28, rd);
        ahb(1'b0, 32'h138, '0);
        chk("rail3 nom", 32'h0003_0AF0, rd);
        ahb(1'b0, 32'h10C, '0);
        chk("rail0 dly", 32'h03E8_03E8, rd);
        ahb(1'b1, 32'h300, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h300, '0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, 32'(hresp));
        pwr_up_req <= 1'b1;
        repeat (20) @(posedge hclk);
        chk("rail_en", 32'h0, 32'(rail_en));
        pwr_up_req <= 1'b0;
    endtask

    task automatic scn_up();
        int n;
        for (int r = 0; r < 4; r++) begin
            ahb(1'b1, 32'h10C + 32'(r) * 32'h10, 32'h0002_0002);
        end
        ahb(1'b1, 32'h200, 32'h104);
        for (int o = 1; o < 5; o++) begin
            ahb(1'b1, 32'h200 + 32'(o) * 32'h4, 32'(o + 1) << 2);
        end
        ahb(1'b1, 32'h00C, 32'h1);
        ahb(1'b1, 32'h000, 32'h3);
        trim_on <= 1'b1;
        pwr_up_req <= 1'b1;
        wait_en(4'h1, n);
        pwr_up_req <= 1'b0;
        repeat (60) @(posedge hclk);
        chk("rail_en held", 32'h1, 32'(rail_en));
        trim_on <= 1'b0;
        wait_en(4'h3, n);
        chk("slot delay", 32'h1, 32'(n >= TICK));
        wait_en(4'h7, n);
        wait_en(4'hF, n);
        repeat (3) @(posedge hclk);
        chk("irq up", 32'h1, 32'(irq));
        ahb(1'b1, 32'h008, 32'h1);
        ahb(1'b0, 32'h008, '0);
        chk("istat clr", 32'h0, rd);
        chk("irq clr", 32'h0, 32'(irq));
    endtask

    task automatic scn_levels();
        rps_mv_t v;
        logic [7:0] e;
        trim_on <= 1'b1;
        foreach (LV[i]) begin
            v = LV[i];
            trim_mv <= v;
            repeat (4) @(posedge hclk);
            e = {3'h0, v >= 16'h0C80, v >= 16'h0BB8, v <= 16'h0960, v <= 16'h0A28,
                 !(v >= 16'h0AF0 && v < 16'h0BB8)};
            chk("dout", 32'(e), 32'(dout));
        end
        trim_on <= 1'b0;
    endtask

    task automatic scn_kill();
        rail_kill <= 4'h4;
        repeat (2) @(posedge hclk);
        chk("kill", 32'hB, 32'(rail_en));
        rail_kill <= 4'h0;
        ahb(1'b0, 32'h008, '0);
        chk("istat kill", 32'h4, rd);
        chk("irq masked", 32'h0, 32'(irq));
        ahb(1'b1, 32'h008, 32'h4);
    endtask

    task automatic scn_down();
        int n;
        pwr_dn_req <= 1'b1;
        wait_en(4'h3, n);
        wait_en(4'h1, n);
        wait_en(4'h0, n);
        chk("down spacing", 32'h1, 32'(n >= TICK));
        ahb(1'b0, 32'h008, '0);
        chk("istat down", 32'h2, rd);
        pwr_dn_req <= 1'b0;
    endtask

    task automatic scn_fwd();
        int n;
        ahb(1'b1, 32'h000, 32'h1);
        pwr_up_req <= 1'b1;
        wait_en(4'hF, n);
        pwr_up_req <= 1'b0;
        pwr_dn_req <= 1'b1;
        wait_en(4'hE, n);
        wait_en(4'hC, n);
        wait_en(4'h8, n);
        wait_en(4'h0, n);
        pwr_dn_req <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        scn_reset();
        scn_up();
        scn_levels();
        scn_kill();
        scn_down();
        scn_fwd();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        end_of_test();
    end
endmodule
